// ---- core/pfta_defs.svh ----
`ifndef PFTA_DEFS_SVH
`define PFTA_DEFS_SVH

// program word and array geometry
`define PFTA_WORD_W        24
`define PFTA_IDX_W         12
`define PFTA_WORDS         4096
`define PFTA_ERASED        24'hFF_FFFF
`define PFTA_LATCH_W       6
`define PFTA_ROW_WORDS     10'h040
`define PFTA_PAGE_WORDS    10'h200
`define PFTA_ONE_WORD      10'h001
`define PFTA_ROW_MASK      12'hFC0
`define PFTA_PAGE_MASK     12'hE00

// lane positions inside a 24-bit program word
`define PFTA_LO_MSB        15
`define PFTA_HI_LSB        16
`define PFTA_HI_MSB        23

// erase and program times
`define PFTA_CLK_PERIOD_NS 10
`define PFTA_T_WORD_NS     2000
`define PFTA_T_ROW_NS      20000
`define PFTA_T_ERASE_NS    40000
`define PFTA_WORD_CYC      ((`PFTA_T_WORD_NS + `PFTA_CLK_PERIOD_NS - 1) / `PFTA_CLK_PERIOD_NS)
`define PFTA_ROW_CYC       ((`PFTA_T_ROW_NS + `PFTA_CLK_PERIOD_NS - 1) / `PFTA_CLK_PERIOD_NS)
`define PFTA_ERASE_CYC     ((`PFTA_T_ERASE_NS + `PFTA_CLK_PERIOD_NS - 1) / `PFTA_CLK_PERIOD_NS)

// serial programmer frame: 4-bit op, 16-bit address, 16-bit data, msb first
`define PFTA_FRAME_LAST    6'h23
`define PFTA_OUT_BITS      5'h10
`define PFTA_SER_SET_PAGE  4'h4
`define PFTA_SER_PROG_WORD 4'h5
`define PFTA_SER_PROG_ROW  4'h6
`define PFTA_SER_ERASE     4'h7
`define PFTA_PAIRS         3

`endif

// ---- core/pfta_pkg.sv ----
package pfta_pkg;

	typedef enum logic [1:0] {
		PFTA_RD_LO = 2'h0,
		PFTA_RD_HI = 2'h1,
		PFTA_WR_LO = 2'h2,
		PFTA_WR_HI = 2'h3
	} pfta_tbl_op_t;

	typedef enum logic [1:0] {
		PFTA_CMD_WORD  = 2'h1,
		PFTA_CMD_ROW   = 2'h2,
		PFTA_CMD_ERASE = 2'h3
	} pfta_cmd_t;

	typedef enum logic [3:0] {
		PFTA_IDLE  = 4'b0001,
		PFTA_PWORD = 4'b0010,
		PFTA_PROW  = 4'b0100,
		PFTA_ERASE = 4'b1000
	} pfta_state_t;

endpackage

// ---- core/pfta_mem_if.sv ----
`include "pfta_defs.svh"

interface pfta_mem_if;
	logic [`PFTA_IDX_W-1:0]  rd_addr;
	logic [`PFTA_WORD_W-1:0] rd_data;
	logic                    wr_en;
	logic                    wr_erase;
	logic [`PFTA_IDX_W-1:0]  wr_addr;
	logic [`PFTA_WORD_W-1:0] wr_data;

	modport ctrl (output rd_addr, input rd_data, output wr_en, output wr_erase, output wr_addr, output wr_data);
	modport mem  (input rd_addr, output rd_data, input wr_en, input wr_erase, input wr_addr, input wr_data);
endinterface

// ---- core/pfta_flash_array.sv ----
`include "pfta_defs.svh"

module pfta_flash_array
	import pfta_pkg::*;
(
	input  wire logic core_clk_i, // system clock
	pfta_mem_if.mem   mem         // array port from the controller
);

	logic [`PFTA_WORD_W-1:0] cells [`PFTA_WORDS];

	// programming can only clear bits; only erase brings them back to one
	always_ff @(posedge core_clk_i) begin
		if (mem.wr_en) begin
			if (mem.wr_erase) begin
				cells[mem.wr_addr] <= `PFTA_ERASED;
			end else begin
				cells[mem.wr_addr] <= cells[mem.wr_addr] & mem.wr_data;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		mem.rd_data <= cells[mem.rd_addr];
	end

endmodule // pfta_flash_array

// ---- core/pfta_top.sv ----
`include "pfta_defs.svh"

module pfta_top
	import pfta_pkg::*;
(
	input  wire logic                core_clk_i,                   // system clock
	input  wire logic                resetn_i,                     // async reset, active low
	input  wire logic                page_wr_i,                    // load table page register
	input  wire logic [7:0]          page_data_i,                  // new page value
	output logic      [7:0]          table_page_register_o,        // current page
	input  wire logic                op_valid_i,                   // table operation request
	input  wire pfta_tbl_op_t        op_kind_i,                    // read/write, low/high
	input  wire logic                op_byte_i,                    // byte size when set
	input  wire logic [15:0]         op_effective_address_i,       // address from working register
	input  wire logic [15:0]         op_wdata_i,                   // write data
	output logic                     op_ready_o,                   // core may issue
	output logic                     op_done_o,                    // operation finished pulse
	output logic      [15:0]         op_rdata_o,                   // read result
	input  wire logic                cmd_valid_i,                  // program or erase command
	input  wire pfta_cmd_t           cmd_kind_i,                   // word, row or page erase
	output logic                     cmd_accept_o,                 // command started pulse
	output logic                     cmd_reject_o,                 // command refused pulse
	output logic                     flash_busy_o,                 // program or erase running
	input  wire logic                master_clear_line_n_i,        // low selects serial programming
	input  wire logic [1:0]          pgm_pair_sel_i,               // selected programming pair
	input  wire logic [`PFTA_PAIRS-1:0] programming_clock_pin_i,   // programmer clocks
	input  wire logic [`PFTA_PAIRS-1:0] programming_data_pin_i,    // programmer data in
	output logic      [`PFTA_PAIRS-1:0] programming_data_pin_o,    // device data out
	output logic      [`PFTA_PAIRS-1:0] programming_data_pin_oe_n_o, // low while device drives
	output logic                     serial_mode_o                 // serial programming active
);

	pfta_mem_if mem_bus ();

	pfta_flash_array u_array (
		.core_clk_i (core_clk_i),
		.mem        (mem_bus.mem)
	);

	function automatic logic [`PFTA_IDX_W-1:0] word_index(input logic [23:0] addr);
		// two address units per instruction word; bit 0 is the byte lane
		return addr[`PFTA_IDX_W:1];
	endfunction

	function automatic logic [`PFTA_WORD_W-1:0] lane_merge(input logic [23:0] old, input logic hi,
		input logic byte_sz, input logic a0, input logic [15:0] d);
		logic [`PFTA_WORD_W-1:0] w;
		w = old;
		if (!hi && !byte_sz) begin
			w[`PFTA_LO_MSB:0] = d;
		end else if (!hi) begin
			if (a0) begin
				w[15:8] = d[7:0];
			end else begin
				w[7:0] = d[7:0];
			end
		end else if (!byte_sz || !a0) begin
			w[`PFTA_HI_MSB:`PFTA_HI_LSB] = d[7:0];
		end
		return w;
	endfunction

	function automatic logic [15:0] lane_pick(input logic [23:0] w, input logic hi,
		input logic byte_sz, input logic a0);
		logic [15:0] r;
		r = 16'h0000;
		if (!hi && !byte_sz) begin
			r = w[`PFTA_LO_MSB:0];
		end else if (!hi) begin
			r[7:0] = a0 ? w[15:8] : w[7:0];
		end else if (!byte_sz || !a0) begin
			r[7:0] = w[`PFTA_HI_MSB:`PFTA_HI_LSB];
		end
		return r;
	endfunction

	// pin synchronisers: {sel, master_clear_line_n, data, clock}
	logic [2*`PFTA_PAIRS+2:0] sync1_reg;
	logic [2*`PFTA_PAIRS+2:0] sync2_reg;
	logic                     pclk_prev_reg;

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end else begin
			sync1_reg <= {pgm_pair_sel_i, master_clear_line_n_i, programming_data_pin_i, programming_clock_pin_i};
			sync2_reg <= sync1_reg;
		end
	end

	logic [1:0] pair_s;
	logic       pair_ok;
	logic       serial_mode;
	logic       pclk_s;
	logic       pdat_s;
	logic       pclk_rise;

	assign pair_s      = sync2_reg[2*`PFTA_PAIRS+2:2*`PFTA_PAIRS+1];
	assign pair_ok     = (pair_s < 2'(`PFTA_PAIRS));
	assign serial_mode = !sync2_reg[2*`PFTA_PAIRS] && pair_ok;
	assign pclk_s      = pair_ok && sync2_reg[pair_s];
	assign pdat_s      = pair_ok && sync2_reg[`PFTA_PAIRS + pair_s];
	assign pclk_rise   = pclk_s && !pclk_prev_reg;

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pclk_prev_reg <= 1'b0;
		end else begin
			pclk_prev_reg <= pclk_s;
		end
	end

	// serial frame engine
	logic [35:0] ser_shift_reg;
	logic [5:0]  ser_cnt_reg;
	logic        ser_fire_reg;
	logic        ser_rd_wait_reg;
	logic [15:0] ser_out_reg;
	logic [4:0]  ser_out_cnt_reg;
	logic [3:0]  ser_op;

	assign ser_op = ser_shift_reg[35:32];

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ser_shift_reg   <= '0;
			ser_cnt_reg     <= '0;
			ser_fire_reg    <= 1'b0;
			ser_rd_wait_reg <= 1'b0;
			ser_out_reg     <= '0;
			ser_out_cnt_reg <= '0;
		end else if (!serial_mode) begin
			ser_cnt_reg     <= '0;
			ser_fire_reg    <= 1'b0;
			ser_rd_wait_reg <= 1'b0;
			ser_out_cnt_reg <= '0;
		end else begin
			ser_fire_reg <= 1'b0;
			if (pclk_rise && ser_out_cnt_reg == '0 && !ser_rd_wait_reg && !ser_fire_reg) begin
				ser_shift_reg <= {ser_shift_reg[34:0], pdat_s};
				if (ser_cnt_reg == `PFTA_FRAME_LAST) begin
					ser_cnt_reg  <= '0;
					ser_fire_reg <= 1'b1;
				end else begin
					ser_cnt_reg <= ser_cnt_reg + 6'h01;
				end
			end
			if (pclk_rise && ser_out_cnt_reg != '0) begin
				ser_out_reg     <= {ser_out_reg[14:0], 1'b0};
				ser_out_cnt_reg <= ser_out_cnt_reg - 5'h01;
			end
			if (ser_fire_reg && ser_op[3:1] == 3'h0) begin
				ser_rd_wait_reg <= 1'b1;
			end
			if (ser_rd_wait_reg && op_done_o) begin
				ser_out_reg     <= op_rdata_o;
				ser_out_cnt_reg <= `PFTA_OUT_BITS;
				ser_rd_wait_reg <= 1'b0;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < `PFTA_PAIRS; i++) begin
			programming_data_pin_o[i]      = ser_out_reg[15];
			programming_data_pin_oe_n_o[i] = !(serial_mode && ser_out_cnt_reg != '0 && pair_s == 2'(i));
		end
	end

	// request merge: the programmer reuses the table path, never a private one
	logic         req_valid;
	pfta_tbl_op_t req_kind;
	logic         req_byte;
	logic [15:0]  req_ea;
	logic [15:0]  req_wdata;
	logic         cmd_go;
	pfta_cmd_t    cmd_sel;
	logic         page_load;
	logic [7:0]   page_val;

	assign op_ready_o = !serial_mode;
	assign req_valid  = serial_mode ? (ser_fire_reg && ser_op[3:2] == 2'h0) : op_valid_i;
	assign req_kind   = serial_mode ? pfta_tbl_op_t'(ser_op[1:0]) : op_kind_i;
	assign req_byte   = serial_mode ? 1'b0 : op_byte_i;
	assign req_ea     = serial_mode ? ser_shift_reg[31:16] : op_effective_address_i;
	assign req_wdata  = serial_mode ? ser_shift_reg[15:0] : op_wdata_i;
	assign cmd_go     = serial_mode ? (ser_fire_reg && ser_op[3:2] == 2'h1 && |ser_op[1:0]) : cmd_valid_i;
	assign cmd_sel    = serial_mode ? pfta_cmd_t'(ser_op[1:0]) : cmd_kind_i;
	assign page_load  = serial_mode ? (ser_fire_reg && ser_op == `PFTA_SER_SET_PAGE) : page_wr_i;
	assign page_val   = serial_mode ? ser_shift_reg[7:0] : page_data_i;

	logic [7:0]  page_reg;
	logic [23:0] req_addr;

	assign table_page_register_o = page_reg;
	assign req_addr              = {page_reg, req_ea};

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			page_reg <= 8'h00;
		end else if (page_load) begin
			page_reg <= page_val;
		end
	end

	// two-stage read pipe: array register, then lane select
	logic p1_valid_reg;
	logic p1_hi_reg;
	logic p1_byte_reg;
	logic p1_a0_reg;
	logic p1_read_reg;

	assign mem_bus.rd_addr = word_index(req_addr);

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			p1_valid_reg <= 1'b0;
			p1_hi_reg    <= 1'b0;
			p1_byte_reg  <= 1'b0;
			p1_a0_reg    <= 1'b0;
			p1_read_reg  <= 1'b0;
			op_done_o    <= 1'b0;
			op_rdata_o   <= 16'h0000;
		end else begin
			p1_valid_reg <= req_valid;
			p1_hi_reg    <= req_kind == PFTA_RD_HI || req_kind == PFTA_WR_HI;
			p1_byte_reg  <= req_byte;
			p1_a0_reg    <= req_ea[0];
			p1_read_reg  <= req_kind == PFTA_RD_LO || req_kind == PFTA_RD_HI;
			op_done_o    <= p1_valid_reg;
			if (p1_valid_reg && p1_read_reg) begin
				op_rdata_o <= lane_pick(mem_bus.rd_data, p1_hi_reg, p1_byte_reg, p1_a0_reg);
			end
		end
	end

	// write latches hold one row; table writes land here, programming moves them
	logic [`PFTA_WORD_W-1:0] latch_mem [2**`PFTA_LATCH_W];
	logic [`PFTA_IDX_W-1:0]  last_idx_reg;
	logic [`PFTA_LATCH_W-1:0] req_lidx;
	logic                     latch_clear;

	assign req_lidx = req_addr[`PFTA_LATCH_W:1];

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 2**`PFTA_LATCH_W; i++) begin
				latch_mem[i] <= `PFTA_ERASED;
			end
			last_idx_reg <= '0;
		end else if (latch_clear) begin
			for (int i = 0; i < 2**`PFTA_LATCH_W; i++) begin
				latch_mem[i] <= `PFTA_ERASED;
			end
		end else if (req_valid && (req_kind == PFTA_WR_LO || req_kind == PFTA_WR_HI)) begin
			latch_mem[req_lidx] <= lane_merge(latch_mem[req_lidx], req_kind == PFTA_WR_HI,
				req_byte, req_ea[0], req_wdata);
			last_idx_reg <= word_index(req_addr);
		end
	end

	// program / erase sequencer
	pfta_state_t              state_reg;
	logic [11:0]              tmr_reg;
	logic [9:0]               step_reg;
	logic [`PFTA_IDX_W-1:0]   base_reg;
	logic [9:0]               step_lim;
	logic [11:0]              dur_last;
	logic                     seq_end;

	always_comb begin
		case (state_reg)
			PFTA_PWORD: begin
				step_lim = `PFTA_ONE_WORD;
				dur_last = 12'(`PFTA_WORD_CYC - 1);
			end
			PFTA_PROW: begin
				step_lim = `PFTA_ROW_WORDS;
				dur_last = 12'(`PFTA_ROW_CYC - 1);
			end
			PFTA_ERASE: begin
				step_lim = `PFTA_PAGE_WORDS;
				dur_last = 12'(`PFTA_ERASE_CYC - 1);
			end
			default: begin
				step_lim = 10'h000;
				dur_last = 12'h000;
			end
		endcase
	end

	assign seq_end      = state_reg != PFTA_IDLE && tmr_reg == dur_last;
	assign latch_clear  = seq_end && state_reg != PFTA_ERASE;
	assign flash_busy_o = state_reg != PFTA_IDLE;
	assign cmd_accept_o = cmd_go && state_reg == PFTA_IDLE;
	assign cmd_reject_o = cmd_go && state_reg != PFTA_IDLE;
	assign serial_mode_o = serial_mode;

	assign mem_bus.wr_en    = state_reg != PFTA_IDLE && step_reg < step_lim;
	assign mem_bus.wr_erase = state_reg == PFTA_ERASE;
	assign mem_bus.wr_addr  = base_reg | {2'b00, step_reg};
	assign mem_bus.wr_data  = latch_mem[base_reg[`PFTA_LATCH_W-1:0] | step_reg[`PFTA_LATCH_W-1:0]];

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= PFTA_IDLE;
			tmr_reg   <= 12'h000;
			step_reg  <= 10'h000;
			base_reg  <= '0;
		end else begin
			case (state_reg)
				PFTA_IDLE: begin
					tmr_reg  <= 12'h000;
					step_reg <= 10'h000;
					if (cmd_go) begin
						case (cmd_sel)
							PFTA_CMD_WORD: begin
								state_reg <= PFTA_PWORD;
								base_reg  <= last_idx_reg;
							end
							PFTA_CMD_ROW: begin
								state_reg <= PFTA_PROW;
								base_reg  <= last_idx_reg & `PFTA_ROW_MASK;
							end
							PFTA_CMD_ERASE: begin
								state_reg <= PFTA_ERASE;
								base_reg  <= last_idx_reg & `PFTA_PAGE_MASK;
							end
							default: state_reg <= PFTA_IDLE;
						endcase
					end
				end
				PFTA_PWORD, PFTA_PROW, PFTA_ERASE: begin
					tmr_reg <= tmr_reg + 12'h001;
					if (step_reg < step_lim) begin
						step_reg <= step_reg + 10'h001;
					end
					if (seq_end) begin
						state_reg <= PFTA_IDLE;
					end
				end
				default: state_reg <= PFTA_IDLE;
			endcase
		end
	end

endmodule // pfta_top

// ---- dv/pfta_properties.sv ----
`include "pfta_defs.svh"

module pfta_props
	import pfta_pkg::*;
(
	input wire logic         core_clk_i,                  // clock
	input wire logic         resetn_i,                    // reset, active low
	input wire logic         page_wr_i,                   // page load
	input wire logic [7:0]   page_data_i,                 // page value
	input wire logic [7:0]   table_page_register_o,       // page register
	input wire logic         op_valid_i,                  // table request
	input wire pfta_tbl_op_t op_kind_i,                   // table op kind
	input wire logic         op_ready_o,                  // core may issue
	input wire logic         op_done_o,                   // op finished
	input wire logic [15:0]  op_rdata_o,                  // read result
	input wire logic         cmd_valid_i,                 // command request
	input wire pfta_cmd_t    cmd_kind_i,                  // command kind
	input wire logic         cmd_accept_o,                // command taken
	input wire logic         cmd_reject_o,                // command refused
	input wire logic         flash_busy_o,                // busy level
	input wire logic         serial_mode_o,               // serial mode
	input wire logic         master_clear_line_n_i,       // master clear pin
	input wire logic [1:0]   pgm_pair_sel_i,              // pair select pins
	input wire logic [2:0]   programming_data_pin_oe_n_o  // data enables
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	logic [12:0] run_reg;
	logic [12:0] exp_reg;

	// length of the current busy run, compared when it ends
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			run_reg <= 13'h0000;
		end else begin
			run_reg <= flash_busy_o ? run_reg + 13'h0001 : 13'h0000;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			exp_reg <= 13'h0000;
		end else if (cmd_accept_o && serial_mode_o) begin
			// serial command kind is not visible on the ports
			exp_reg <= 13'h0000;
		end else if (cmd_accept_o) begin
			case (cmd_kind_i)
				PFTA_CMD_WORD:  exp_reg <= 13'(`PFTA_WORD_CYC);
				PFTA_CMD_ROW:   exp_reg <= 13'(`PFTA_ROW_CYC);
				PFTA_CMD_ERASE: exp_reg <= 13'(`PFTA_ERASE_CYC);
				default:        exp_reg <= 13'h0000;
			endcase
		end
	end

	sequence s_take;
		op_valid_i && op_ready_o;
	endsequence

	property p_done_lat;
		s_take |-> ##2 op_done_o;
	endproperty
	a_done_lat: assert property (p_done_lat) else $error("done not two cycles after request");

	property p_done_cause;
		op_done_o |-> $past(op_valid_i && op_ready_o, 2) || $past(serial_mode_o, 2);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("done without request");

	property p_hi_zero;
		s_take ##0 (op_kind_i == PFTA_RD_HI) |-> ##2 (op_rdata_o[15:8] == 8'h00);
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("high read upper byte not zero");

	property p_ready;
		op_ready_o == !serial_mode_o;
	endproperty
	a_ready: assert property (p_ready) else $error("ready not tied to mode");

	property p_reject;
		cmd_valid_i |-> (cmd_reject_o == flash_busy_o) && (cmd_accept_o == !flash_busy_o);
	endproperty
	a_reject: assert property (p_reject) else $error("accept or reject wrong for busy");

	property p_start;
		cmd_accept_o && (cmd_kind_i inside {PFTA_CMD_WORD, PFTA_CMD_ROW, PFTA_CMD_ERASE}) |=> flash_busy_o;
	endproperty
	a_start: assert property (p_start) else $error("busy not raised after accept");

	// one cycle of slack: the end edge may be counted either way
	property p_busy_len;
		$fell(flash_busy_o) && exp_reg != 13'h0000 |-> (run_reg + 13'h0001 >= exp_reg) && (run_reg <= exp_reg);
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong for command");

	property p_page;
		page_wr_i && !serial_mode_o |=> table_page_register_o == $past(page_data_i);
	endproperty
	a_page: assert property (p_page) else $error("page register not loaded");

	property p_rdata;
		$changed(op_rdata_o) |-> op_done_o;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved without done");

	property p_oe;
		!(&programming_data_pin_oe_n_o) |-> serial_mode_o;
	endproperty
	a_oe: assert property (p_oe) else $error("data pin driven outside serial mode");

	// two synchroniser stages between the pins and the mode
	property p_mode;
		serial_mode_o == $past(!master_clear_line_n_i && (pgm_pair_sel_i != 2'h3), 2);
	endproperty
	a_mode: assert property (p_mode) else $error("serial mode does not follow pins");
endmodule // pfta_props

bind pfta_top pfta_props u_props (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .page_wr_i(page_wr_i),
	.page_data_i(page_data_i), .table_page_register_o(table_page_register_o), .op_valid_i(op_valid_i),
	.op_kind_i(op_kind_i), .op_ready_o(op_ready_o), .op_done_o(op_done_o), .op_rdata_o(op_rdata_o),
	.cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_accept_o(cmd_accept_o),
	.cmd_reject_o(cmd_reject_o), .flash_busy_o(flash_busy_o), .serial_mode_o(serial_mode_o),
	.programming_data_pin_oe_n_o(programming_data_pin_oe_n_o), .master_clear_line_n_i(master_clear_line_n_i),
	.pgm_pair_sel_i(pgm_pair_sel_i));

// ---- dv/pfta_prog_model.sv ----
module pfta_prog_model (
	input  wire logic       core_clk_i, // clock for pacing
	input  wire logic [2:0] dev_data_i, // device data out
	input  wire logic [2:0] dev_oe_n_i, // device enables
	output logic            master_clear_line_n_o,   // master clear
	output logic [1:0]      pair_sel_o, // selected pair
	output logic [2:0]      pgc_o,      // clock pins
	output logic [2:0]      pgd_o       // data wire level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       drv;
	logic       clk_lvl;
	logic [1:0] pair_sel_o_q;

	assign pair_sel_o = pair_sel_o_q;
	// clock only on the selected pair, low between frames
	assign pgc_o = 3'(3'h1 << pair_sel_o_q) & {3{clk_lvl}};
	assign pgd_o = (dev_oe_n_i & {3{drv}}) | (~dev_oe_n_i & dev_data_i);

	initial begin
		master_clear_line_n_o = 1'b1;
		pair_sel_o_q = 2'h3;
		drv = 1'b0;
		clk_lvl = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic enter(input logic [1:0] p);
		pair_sel_o_q = p;
		master_clear_line_n_o = 1'b0;
		tick(4);
	endtask

	task automatic leave();
		master_clear_line_n_o = 1'b1;
		pair_sel_o_q = 2'h3;
		tick(4);
	endtask

	task automatic send(input logic [35:0] f);
		for (int i = 35; i >= 0; i--) begin
			drv = f[i];
			tick(3);
			clk_lvl = 1'b1;
			tick(3);
			clk_lvl = 1'b0;
		end
		// released line flips so a stale bit cannot pass as data
		drv = ~drv;
	endtask

	task automatic recv(output logic [15:0] v);
		v = 16'h0000;
		tick(12);
		for (int i = 0; i < 16; i++) begin
			v = {v[14:0], pgd_o[pair_sel_o_q]};
			clk_lvl = 1'b1;
			tick(4);
			clk_lvl = 1'b0;
			tick(4);
		end
	endtask
endmodule // pfta_prog_model

// ---- dv/pfta_top_tb.sv ----
`define PFTA_CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module pfta_top_tb
	import pfta_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         core_clk = 1'b0;
	logic         resetn = 1'b0;
	logic         page_wr = 1'b0;
	logic [7:0]   page_data = 8'h00;
	logic [7:0]   page_reg;
	logic         op_valid = 1'b0;
	pfta_tbl_op_t op_kind = PFTA_RD_LO;
	logic         op_byte = 1'b0;
	logic [15:0]  op_ea = 16'h0000;
	logic [15:0]  op_wd = 16'h0000;
	logic         op_ready, op_done, cmd_accept, cmd_reject, flash_busy, serial_mode, master_clear_line_n;
	logic [15:0]  op_rdata;
	logic         cmd_valid = 1'b0;
	pfta_cmd_t    cmd_kind = PFTA_CMD_WORD;
	logic [1:0]   pair_sel;
	logic [2:0]   pgc, pgd, dev_d, dev_oe_n;
	int           mismatches = 0;
	int           checks_done = 0;

	always #5 core_clk = ~core_clk;

	pfta_top DUT (.core_clk_i(core_clk), .resetn_i(resetn), .page_wr_i(page_wr), .page_data_i(page_data),
		.table_page_register_o(page_reg), .op_valid_i(op_valid), .op_kind_i(op_kind), .op_byte_i(op_byte),
		.op_effective_address_i(op_ea), .op_wdata_i(op_wd), .op_ready_o(op_ready), .op_done_o(op_done),
		.op_rdata_o(op_rdata), .cmd_valid_i(cmd_valid), .cmd_kind_i(cmd_kind), .cmd_accept_o(cmd_accept),
		.cmd_reject_o(cmd_reject), .flash_busy_o(flash_busy), .master_clear_line_n_i(master_clear_line_n),
		.pgm_pair_sel_i(pair_sel), .programming_clock_pin_i(pgc), .programming_data_pin_i(pgd),
		.programming_data_pin_o(dev_d), .programming_data_pin_oe_n_o(dev_oe_n), .serial_mode_o(serial_mode));

	pfta_prog_model m (.core_clk_i(core_clk), .dev_data_i(dev_d), .dev_oe_n_i(dev_oe_n), .master_clear_line_n_o(master_clear_line_n),
		.pair_sel_o(pair_sel), .pgc_o(pgc), .pgd_o(pgd));

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic op(input pfta_tbl_op_t k, input logic b, input logic [15:0] ea, input logic [15:0] wd,
		output logic [15:0] rd);
		int n;
		op_kind = k;
		op_byte = b;
		op_ea = ea;
		op_wd = wd;
		op_valid = 1'b1;
		tick(1);
		op_valid = 1'b0;
		n = 0;
		while (op_done !== 1'b1 && n < 8) begin
			tick(1);
			n++;
		end
		if (n == 8) begin
			mismatches++;
			tally_and_finish();
		end
		rd = op_rdata;
	endtask

	task automatic cmd(input pfta_cmd_t k, input logic busy_exp);
		cmd_kind = k;
		cmd_valid = 1'b1;
		#1;
		`PFTA_CHK("cmd_accept", !busy_exp, cmd_accept);
		`PFTA_CHK("cmd_reject", busy_exp, cmd_reject);
		tick(1);
		cmd_valid = 1'b0;
		tick(1);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (flash_busy !== 1'b0 && n < 5000) begin
			tick(1);
			n++;
		end
		if (n == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	endtask

	task automatic s_page();
		page_data = 8'hA5;
		page_wr = 1'b1;
		tick(1);
		page_wr = 1'b0;
		`PFTA_CHK("page_reg", 8'hA5, page_reg);
	endtask

	task automatic s_word();
		logic [15:0] r;
		op(PFTA_WR_LO, 1'b0, 16'h0020, 16'hFFFF, r);
		cmd(PFTA_CMD_ERASE, 1'b0);
		cmd(PFTA_CMD_WORD, 1'b1);
		op(PFTA_RD_LO, 1'b0, 16'h0000, 16'h0000, r);
		`PFTA_CHK("read_busy", 16'hFFFF, r);
		wait_idle();
		op(PFTA_RD_LO, 1'b0, 16'h0020, 16'h0000, r);
		`PFTA_CHK("erased_lo", 16'hFFFF, r);
		op(PFTA_RD_HI, 1'b0, 16'h0020, 16'h0000, r);
		`PFTA_CHK("erased_hi", 16'h00FF, r);
		op(PFTA_WR_LO, 1'b0, 16'h0020, 16'h1234, r);
		op(PFTA_WR_HI, 1'b0, 16'h0020, 16'h0056, r);
		cmd(PFTA_CMD_WORD, 1'b0);
		wait_idle();
		op(PFTA_RD_LO, 1'b0, 16'h0020, 16'h0000, r);
		`PFTA_CHK("word_lo", 16'h1234, r);
		op(PFTA_RD_HI, 1'b0, 16'h0020, 16'h0000, r);
		`PFTA_CHK("word_hi", 16'h0056, r);
		op(PFTA_RD_LO, 1'b1, 16'h0021, 16'h0000, r);
		`PFTA_CHK("byte_lo_odd", 16'h0012, r);
		op(PFTA_RD_HI, 1'b1, 16'h0021, 16'h0000, r);
		`PFTA_CHK("byte_hi_odd", 16'h0000, r);
	endtask

	task automatic s_row();
		logic [15:0] r;
		op(PFTA_WR_LO, 1'b0, 16'h0080, 16'hABCD, r);
		op(PFTA_WR_LO, 1'b0, 16'h0082, 16'h1111, r);
		cmd(PFTA_CMD_ROW, 1'b0);
		wait_idle();
		op(PFTA_RD_LO, 1'b0, 16'h0080, 16'h0000, r);
		`PFTA_CHK("row_w0", 16'hABCD, r);
		op(PFTA_RD_LO, 1'b0, 16'h0082, 16'h0000, r);
		`PFTA_CHK("row_w1", 16'h1111, r);
		op(PFTA_RD_LO, 1'b0, 16'h0084, 16'h0000, r);
		`PFTA_CHK("row_w2", 16'hFFFF, r);
	endtask

	task automatic s_serial();
		logic [15:0] r;
		m.enter(2'h1);
		`PFTA_CHK("ready_serial", 1'b0, op_ready);
		m.send({4'h0, 16'h0020, 16'h0000});
		m.recv(r);
		`PFTA_CHK("serial_read", 16'h1234, r);
		m.send({4'h4, 16'h0000, 16'h003C});
		tick(2);
		`PFTA_CHK("serial_page", 8'h3C, page_reg);
		m.send({4'h2, 16'h0040, 16'h0F0F});
		m.send({4'h5, 16'h0000, 16'h0000});
		tick(2);
		`PFTA_CHK("serial_busy", 1'b1, flash_busy);
		tick(200);
		`PFTA_CHK("serial_idle", 1'b0, flash_busy);
		m.send({4'h0, 16'h0040, 16'h0000});
		m.recv(r);
		`PFTA_CHK("serial_prog", 16'h0F0F, r);
		m.leave();
		`PFTA_CHK("ready_back", 1'b1, op_ready);
	endtask

	initial begin
		tick(3);
		resetn = 1'b1;
		s_page();
		s_word();
		s_row();
		s_serial();
		tally_and_finish();
	end
endmodule // pfta_top_tb
